// ==== core/cfc_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef CFC_MAP_SVH
`define CFC_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CFC_OFF_CTRL      8'h00
`define CFC_OFF_OPND_A    8'h04
`define CFC_OFF_OPND_B    8'h08
`define CFC_OFF_CMD       8'h0C
`define CFC_OFF_RESULT    8'h10
`define CFC_OFF_STATUS    8'h14
`define CFC_OFF_STK_PTR   8'h18
`define CFC_OFF_STK_TOP   8'h1C
`define CFC_OFF_PORT_DIR  8'h20
`define CFC_OFF_PINS      8'h24

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CFC_CTRL_SPD_LSB  0
`define CFC_CTRL_ASYNC    4
`define CFC_CTRL_TXD      8

// ----------------------------------------
// Status word bits and reset value
// ----------------------------------------
`define CFC_PSW_C         0
`define CFC_PSW_Z         1
`define CFC_PSW_I         2
`define CFC_PSW_D         3
`define CFC_PSW_T         5
`define CFC_PSW_V         6
`define CFC_PSW_N         7
`define CFC_PSW_RST       8'h04

// ----------------------------------------
// Commands
// ----------------------------------------
`define CFC_CMD_ADC       4'h1
`define CFC_CMD_SBC       4'h2
`define CFC_CMD_MUL       4'h3
`define CFC_CMD_DIV       4'h4
`define CFC_CMD_PUSH      4'h5
`define CFC_CMD_PULL      4'h6
`define CFC_CMD_SETD      4'h7
`define CFC_CMD_CLRD      4'h8

// ----------------------------------------
// Speed modes and divide counts
// ----------------------------------------
`define CFC_SPD_HIGH      2'h0
`define CFC_SPD_MID       2'h1
`define CFC_SPD_LOW       2'h2
`define CFC_DIV_HIGH      4'h2
`define CFC_DIV_MID       4'h8
`define CFC_DIV_LOW       4'h2

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define CFC_RESP_OKAY     2'h0
`define CFC_RESP_SLVERR   2'h2

`endif

// ==== core/cfc_pkg.sv ====
// Types shared by the core flag and clock block
package cfc_pkg;

    typedef enum logic [1:0] {EX_IDLE, EX_WAIT} cfc_exec_state_type;

    typedef struct packed {
        logic rxd;
        logic sclk;
        logic flash_mode_select_pin;
    } cfc_ser_in_type;

    typedef struct packed {
        logic txd;
        logic busy;
    } cfc_ser_out_type;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] psw;
    } cfc_alu_out_type;

endpackage

// ==== core/cfc_clk_div.sv ====
// Internal cpu clock enable from main clock or sub oscillator
`timescale 1ns/1ps
`include "cfc_map.svh"

module cfc_clk_div (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Speed selection
    input  wire logic [1:0] speed,
    input  wire logic       sub_osc_input,
    // Internal clock enable
    output logic            phi_en
);

    logic [2:0] sub_sync_q;
    logic       sub_lvl_q;
    logic [3:0] cnt_q;
    logic       phi_q;

    // ----------------------------------------
    // Sub oscillator sampling
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sub_sync_q <= 3'h0;
            sub_lvl_q  <= 1'b0;
        end else begin
            sub_sync_q <= {sub_sync_q[1:0], sub_osc_input};
            if (sub_sync_q[1] == sub_sync_q[2]) begin
                sub_lvl_q <= sub_sync_q[2];
            end
        end
    end

    wire sub_rise = (sub_sync_q[1] == sub_sync_q[2]) && sub_sync_q[2] && !sub_lvl_q;

    // ----------------------------------------
    // Divider
    // ----------------------------------------
    wire       tick  = (speed == `CFC_SPD_LOW) ? sub_rise : 1'b1;
    wire [3:0] limit = (speed == `CFC_SPD_MID) ? `CFC_DIV_MID :
                       (speed == `CFC_SPD_LOW) ? `CFC_DIV_LOW : `CFC_DIV_HIGH;
    wire       wrap  = tick && (cnt_q >= limit - 4'h1);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 4'h0;
            phi_q <= 1'b0;
        end else begin
            phi_q <= wrap;
            if (wrap) begin
                cnt_q <= 4'h0;
            end else if (tick) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    assign phi_en = phi_q;

endmodule

// ==== core/cfc_core.sv ====
// Status word, decimal and multiply/divide datapath with AXI4-Lite registers
`timescale 1ns/1ps
`include "cfc_map.svh"

// Contract
// - After reset the status word has its interrupt disable flag at one.
// - A status push stores the word so it reads at stack pointer plus one, and a pull restores it.
// - With the decimal flag set only add-with-carry and subtract-with-borrow are decimal-adjusted.
// - Negative, overflow and zero flags after decimal add or subtract are not to be trusted.
// - In decimal arithmetic carry is one on a carry and zero on a borrow.
// - Multiply and divide ignore the index and decimal flags and leave the status word alone.
// - Multiply and divide change no status bit whatever the operands.
// - Port direction registers are write-only and read back nothing meaningful.
// - The cpu clock is two main periods high speed, eight middle speed, two sub periods low speed.
// - In serial programming the device drives busy and transmit and samples receive.
// - Serial mode two uses asynchronous framing, mode one a synchronous external clock.
module cfc_core #(
    parameter int STK_AW = 4
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   resetn,
    // AXI4-Lite write address and data
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Oscillator and serial programming pins
    input  wire logic                   sub_osc_input,
    input  wire cfc_pkg::cfc_ser_in_type ser_i,
    output cfc_pkg::cfc_ser_out_type    ser_o,
    // Port direction outputs
    output logic [31:0]                 port_dir
);

    localparam int STK_DEPTH = 1 << STK_AW;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0]                 waddr_q;
    logic [31:0]                wdata_q;
    logic [3:0]                 wstrb_q;
    logic                       aw_hold_q;
    logic                       w_hold_q;
    logic                       bvalid_q;
    logic [1:0]                 bresp_q;
    logic                       rvalid_q;
    logic [1:0]                 rresp_q;
    logic [31:0]                rdata_q;
    logic [1:0]                 spd_q;
    logic                       async_q;
    logic                       txd_q;
    logic [7:0]                 opa_q;
    logic [7:0]                 opb_q;
    logic [3:0]                 cmd_q;
    logic [15:0]                result_q;
    logic [7:0]                 psw_q;
    logic [STK_AW-1:0]          sp_q;
    logic [7:0]                 stk_q [STK_DEPTH];
    logic [31:0]                port_dir_q;
    logic [2:0]                 s1_q;
    logic [2:0]                 s2_q;
    logic [2:0]                 s3_q;
    logic [2:0]                 lvl_q;
    cfc_pkg::cfc_ser_out_type   ser_q;
    cfc_pkg::cfc_exec_state_type state_q;
    logic                       phi_en;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        begin
            r = old_v;
            for (int i = 0; i < 4; i++) begin
                if (strb[i]) begin
                    r[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
            return r;
        end
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return ({a[7:2], 2'b00} <= `CFC_OFF_PINS);
    endfunction

    // Decimal nibble step: {carry, digit}
    function automatic logic [4:0] bcd_nib(input logic [3:0] a, input logic [3:0] b,
                                           input logic ci, input logic sub);
        logic [4:0] s;
        begin
            if (!sub) begin
                s = {1'b0, a} + {1'b0, b} + {4'h0, ci};
                if (s > 5'h09) begin
                    s = {1'b1, 4'(s[3:0] + 4'h6)};
                end
            end else begin
                s = {1'b0, a} - {1'b0, b} - {4'h0, ~ci};
                if (s[4]) begin
                    s = {1'b0, 4'(s[3:0] - 4'h6)};
                end else begin
                    s = {1'b1, s[3:0]};
                end
            end
            return s;
        end
    endfunction

    // ----------------------------------------
    // Internal clock enable
    // ----------------------------------------
    cfc_clk_div u_clk_div (
        .clk           (clk),
        .resetn        (resetn),
        .speed         (spd_q),
        .sub_osc_input (sub_osc_input),
        .phi_en        (phi_en)
    );

    // ----------------------------------------
    // Pin sampling
    // ----------------------------------------
    wire [2:0] pin_raw = {ser_i.rxd, ser_i.sclk, ser_i.flash_mode_select_pin};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    s1_q[g]  <= 1'b0;
                    s2_q[g]  <= 1'b0;
                    s3_q[g]  <= 1'b0;
                    lvl_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= pin_raw[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) begin
                        lvl_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    wire rxd_lvl   = lvl_q[2];
    wire sclk_lvl  = lvl_q[1];
    wire fmode_lvl = lvl_q[0];
    wire ser_async = fmode_lvl && async_q && !sclk_lvl;
    wire ser_sync  = fmode_lvl && !async_q;
    wire ser_mode  = ser_async || ser_sync;
    wire busy      = (state_q == cfc_pkg::EX_WAIT);

    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    wire        cin      = psw_q[`CFC_PSW_C];
    wire        dec      = psw_q[`CFC_PSW_D];
    wire        is_sub   = (cmd_q == `CFC_CMD_SBC);
    wire [8:0]  bin_add  = {1'b0, opa_q} + {1'b0, opb_q} + {8'h00, cin};
    wire [8:0]  bin_sub  = {1'b0, opa_q} + {1'b0, ~opb_q} + {8'h00, cin};
    wire [8:0]  bin_res  = is_sub ? bin_sub : bin_add;
    wire [4:0]  dec_lo   = bcd_nib(opa_q[3:0], opb_q[3:0], cin, is_sub);
    wire [4:0]  dec_hi   = bcd_nib(opa_q[7:4], opb_q[7:4], dec_lo[4], is_sub);
    wire [7:0]  arith    = dec ? {dec_hi[3:0], dec_lo[3:0]} : bin_res[7:0];
    wire        arith_c  = dec ? dec_hi[4] : bin_res[8];
    wire        ovf      = is_sub ? ((opa_q[7] != opb_q[7]) && (bin_res[7] != opa_q[7]))
                                  : ((opa_q[7] == opb_q[7]) && (bin_res[7] != opa_q[7]));
    wire [15:0] product  = {8'h00, opa_q} * {8'h00, opb_q};
    wire [7:0]  quot     = (opb_q == 8'h00) ? 8'hFF : opa_q / opb_q;
    wire [7:0]  remd     = (opb_q == 8'h00) ? opa_q : opa_q % opb_q;
    wire [STK_AW-1:0] sp_up = sp_q + STK_AW'(1);

    // Flags N, V, Z follow the binary sum even in decimal mode
    wire [7:0] arith_psw = {bin_res[7], ovf, psw_q[5:2], (bin_res[7:0] == 8'h00),
                            arith_c};

    cfc_pkg::cfc_alu_out_type alu;
    assign alu.hi  = (cmd_q == `CFC_CMD_MUL) ? product[15:8] :
                     (cmd_q == `CFC_CMD_DIV) ? remd : 8'h00;
    assign alu.lo  = (cmd_q == `CFC_CMD_MUL) ? product[7:0] :
                     (cmd_q == `CFC_CMD_DIV) ? quot : arith;
    assign alu.psw = (cmd_q == `CFC_CMD_ADC || cmd_q == `CFC_CMD_SBC) ? arith_psw :
                     (cmd_q == `CFC_CMD_PULL) ? stk_q[sp_up] :
                     (cmd_q == `CFC_CMD_SETD) ? (psw_q | 8'h08) :
                     (cmd_q == `CFC_CMD_CLRD) ? (psw_q & 8'hF7) : psw_q;

    wire exec      = busy && phi_en;
    wire exec_res  = exec && (cmd_q == `CFC_CMD_ADC || cmd_q == `CFC_CMD_SBC ||
                              cmd_q == `CFC_CMD_MUL || cmd_q == `CFC_CMD_DIV);

    // ----------------------------------------
    // Register read mux
    // ----------------------------------------
    function automatic logic [31:0] reg_read(input logic [7:0] a);
        logic [7:0] w;
        begin
            w = {a[7:2], 2'b00};
            case (w)
                `CFC_OFF_CTRL:     reg_read = {23'h0, txd_q, 3'h0, async_q, 2'h0, spd_q};
                `CFC_OFF_OPND_A:   reg_read = {24'h0, opa_q};
                `CFC_OFF_OPND_B:   reg_read = {24'h0, opb_q};
                `CFC_OFF_CMD:      reg_read = {31'h0, busy};
                `CFC_OFF_RESULT:   reg_read = {16'h0, result_q};
                `CFC_OFF_STATUS:   reg_read = {24'h0, psw_q};
                `CFC_OFF_STK_PTR:  reg_read = {{(32-STK_AW){1'b0}}, sp_q};
                `CFC_OFF_STK_TOP:  reg_read = {24'h0, stk_q[sp_up]};
                `CFC_OFF_PINS:     reg_read = {27'h0, ser_q.busy, ser_mode, fmode_lvl,
                                               sclk_lvl, rxd_lvl};
                default:           reg_read = 32'h0;
            endcase
        end
    endfunction

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    wire        aw_fire  = s_axi_awvalid && !aw_hold_q;
    wire        w_fire   = s_axi_wvalid && !w_hold_q;
    wire        wr_fire  = aw_hold_q && w_hold_q && !bvalid_q;
    wire        ar_fire  = s_axi_arvalid && !rvalid_q;
    wire [7:0]  wa       = {waddr_q[7:2], 2'b00};
    wire [31:0] wbase    = (wa == `CFC_OFF_PORT_DIR) ? port_dir_q : reg_read(waddr_q);
    wire [31:0] wval     = strb_merge(wbase, wdata_q, wstrb_q);
    wire        wr_ctrl  = wr_fire && (wa == `CFC_OFF_CTRL);
    wire        wr_opa   = wr_fire && (wa == `CFC_OFF_OPND_A);
    wire        wr_opb   = wr_fire && (wa == `CFC_OFF_OPND_B);
    wire        wr_cmd   = wr_fire && (wa == `CFC_OFF_CMD) && !busy;
    wire        wr_psw   = wr_fire && (wa == `CFC_OFF_STATUS);
    wire        wr_sp    = wr_fire && (wa == `CFC_OFF_STK_PTR);
    wire        wr_pdir  = wr_fire && (wa == `CFC_OFF_PORT_DIR);

    assign s_axi_awready = !aw_hold_q;
    assign s_axi_wready  = !w_hold_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            waddr_q   <= 8'h00;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `CFC_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                waddr_q   <= s_axi_awaddr;
                aw_hold_q <= 1'b1;
            end
            if (w_fire) begin
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
                w_hold_q <= 1'b1;
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= is_mapped(waddr_q) ? `CFC_RESP_OKAY : `CFC_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= `CFC_RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= reg_read(s_axi_araddr);
            rresp_q  <= is_mapped(s_axi_araddr) ? `CFC_RESP_OKAY : `CFC_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Control and operand registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            spd_q      <= `CFC_SPD_HIGH;
            async_q    <= 1'b0;
            txd_q      <= 1'b1;
            opa_q      <= 8'h00;
            opb_q      <= 8'h00;
            port_dir_q <= 32'h0;
        end else begin
            if (wr_ctrl) begin
                spd_q   <= wval[`CFC_CTRL_SPD_LSB +: 2];
                async_q <= wval[`CFC_CTRL_ASYNC];
                txd_q   <= wval[`CFC_CTRL_TXD];
            end
            if (wr_opa) begin
                opa_q <= wval[7:0];
            end
            if (wr_opb) begin
                opb_q <= wval[7:0];
            end
            if (wr_pdir) begin
                port_dir_q <= wval;
            end
        end
    end

    assign port_dir = port_dir_q;

    // ----------------------------------------
    // Command sequencing on the cpu clock
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q  <= cfc_pkg::EX_IDLE;
            cmd_q    <= 4'h0;
            result_q <= 16'h0;
        end else begin
            case (state_q)
                cfc_pkg::EX_IDLE: begin
                    if (wr_cmd) begin
                        cmd_q   <= wval[3:0];
                        state_q <= cfc_pkg::EX_WAIT;
                    end
                end
                cfc_pkg::EX_WAIT: begin
                    if (phi_en) begin
                        state_q <= cfc_pkg::EX_IDLE;
                    end
                end
                default: state_q <= cfc_pkg::EX_IDLE;
            endcase
            if (exec_res) begin
                result_q <= {alu.hi, alu.lo};
            end
        end
    end

    // ----------------------------------------
    // Status word and stack
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            psw_q <= `CFC_PSW_RST;
            sp_q  <= '1;
        end else begin
            if (exec) begin
                psw_q <= alu.psw;
            end else if (wr_psw) begin
                psw_q <= wval[7:0];
            end
            if (exec && cmd_q == `CFC_CMD_PUSH) begin
                sp_q <= sp_q - STK_AW'(1);
            end else if (exec && cmd_q == `CFC_CMD_PULL) begin
                sp_q <= sp_up;
            end else if (wr_sp) begin
                sp_q <= wval[STK_AW-1:0];
            end
        end
    end

    generate
        for (g = 0; g < STK_DEPTH; g++) begin : g_stk
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    stk_q[g] <= 8'h00;
                end else if (exec && cmd_q == `CFC_CMD_PUSH && sp_q == STK_AW'(g)) begin
                    stk_q[g] <= psw_q;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Serial programming pins
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ser_q <= '{txd: 1'b1, busy: 1'b0};
        end else begin
            ser_q.busy <= ser_mode && busy;
            ser_q.txd  <= ser_mode ? txd_q : 1'b1;
        end
    end

    assign ser_o = ser_q;

endmodule

// ==== verification/cfc_core_sva.sv ====
// Protocol and pin checks for the core flag and clock block
`timescale 1ns/1ps

module cfc_core_sva (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     resetn,
    // Register bus
    input wire logic                     s_axi_awready,
    input wire logic                     s_axi_wready,
    input wire logic [1:0]               s_axi_bresp,
    input wire logic                     s_axi_bvalid,
    input wire logic                     s_axi_bready,
    input wire logic [7:0]               s_axi_araddr,
    input wire logic                     s_axi_arvalid,
    input wire logic                     s_axi_arready,
    input wire logic [31:0]              s_axi_rdata,
    input wire logic [1:0]               s_axi_rresp,
    input wire logic                     s_axi_rvalid,
    input wire logic                     s_axi_rready,
    // Serial programming pins
    input wire cfc_pkg::cfc_ser_in_type  ser_i,
    input wire cfc_pkg::cfc_ser_out_type ser_o
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    rhold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("ar while rvalid");
    rd_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready))
        else $error("rvalid without ar");
    wr_cause_a: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
        else $error("bvalid without aw and w");
    dir_read_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h08 |=> s_axi_rdata == 32'h0)
        else $error("dir reg readable");
    unmap_rd_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h09 |=> s_axi_rresp == 2'h2)
        else $error("unmapped read ok");
    pin_idle_a: assert property (
        !ser_i.flash_mode_select_pin [*8] |-> ser_o.txd && !ser_o.busy)
        else $error("serial pins active");

    cover property (s_axi_rvalid && s_axi_rready);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (!ser_o.txd);
endmodule

bind cfc_core cfc_core_sva chk (.*);

// ==== verification/tb_cfc_core.sv ====
// Self-checking bench for the core flag and clock block
`timescale 1ns/1ps
`include "cfc_map.svh"

module tb_cfc_core;
    logic        clk = 1'b0, resetn = 1'b0, sub_osc_input = 1'b0, osc_run = 1'b1;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, v, port_dir, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    int          err_total = 0, n_tests = 0;
    cfc_pkg::cfc_ser_in_type  ser_i = '0;
    cfc_pkg::cfc_ser_out_type ser_o;

    always #4 clk = ~clk;
    always #44 if (osc_run) sub_osc_input = ~sub_osc_input;

    cfc_core dut (.*);

    task automatic cmp(input string n, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, b;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(negedge clk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            b  = s_axi_bvalid;
            @(posedge clk);
            if (ta && !b) s_axi_awvalid <= 1'b0;
            if (tw && !b) s_axi_wvalid <= 1'b0;
        end while (!b);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic t, r;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge clk);
            t  = s_axi_arready;
            r  = s_axi_rvalid;
            d  = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk);
            if (t && !r) s_axi_arvalid <= 1'b0;
        end while (!r);
    endtask

    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        rd(a, v);
        cmp(n, e, v);
    endtask

    task automatic cmd(input logic [3:0] c);
        int k = 0;
        wr(`CFC_OFF_CMD, {28'h0, c});
        do begin
            rd(`CFC_OFF_CMD, v);
            k++;
        end while (v[0] !== 1'b0 && k < 60);
        cmp("cmd busy", 32'h0, {31'h0, v[0]});
    endtask

    task automatic t_basic;
        rc("status", `CFC_OFF_STATUS, 32'h04);
        wr(`CFC_OFF_STATUS, 32'hC3);
        cmd(`CFC_CMD_PUSH);
        rc("stack top", `CFC_OFF_STK_TOP, 32'hC3);
        wr(`CFC_OFF_STATUS, 32'h0);
        cmd(`CFC_CMD_PULL);
        rc("pulled", `CFC_OFF_STATUS, 32'hC3);
        wr(`CFC_OFF_PORT_DIR, 32'hA5);
        cmp("port_dir", 32'hA5, port_dir);
        rc("dir read", `CFC_OFF_PORT_DIR, 32'h0);
        rc("unmapped", 8'h28, 32'h0);
        cmp("unmapped resp", 32'h2, {30'h0, rs});
        $display("basic test done");
    endtask

    task automatic t_arith;
        wr(`CFC_OFF_STATUS, 32'h08);
        wr(`CFC_OFF_OPND_A, 32'h58);
        wr(`CFC_OFF_OPND_B, 32'h46);
        cmd(`CFC_CMD_ADC);
        rc("bcd sum", `CFC_OFF_RESULT, 32'h04);
        rd(`CFC_OFF_STATUS, v);
        cmp("sum carry", 32'h3, {30'h0, v[3], v[0]});
        wr(`CFC_OFF_STATUS, 32'h09);
        wr(`CFC_OFF_OPND_A, 32'h12);
        wr(`CFC_OFF_OPND_B, 32'h21);
        cmd(`CFC_CMD_SBC);
        rc("bcd diff", `CFC_OFF_RESULT, 32'h91);
        rd(`CFC_OFF_STATUS, v);
        cmp("borrow", 32'h2, {30'h0, v[3], v[0]});
        wr(`CFC_OFF_STATUS, 32'hEB);
        wr(`CFC_OFF_OPND_A, 32'h99);
        wr(`CFC_OFF_OPND_B, 32'h99);
        cmd(`CFC_CMD_MUL);
        rc("product", `CFC_OFF_RESULT, 32'h5B71);
        rc("mul flags", `CFC_OFF_STATUS, 32'hEB);
        wr(`CFC_OFF_OPND_A, 32'h64);
        wr(`CFC_OFF_OPND_B, 32'h07);
        cmd(`CFC_CMD_DIV);
        rc("quotient", `CFC_OFF_RESULT, 32'h020E);
        rc("div flags", `CFC_OFF_STATUS, 32'hEB);
        $display("arith test done");
    endtask

    task automatic t_clk_ser;
        ser_i.rxd <= 1'b1;
        @(posedge clk);
        ser_i.flash_mode_select_pin <= 1'b1;
        osc_run = 1'b0;
        wr(`CFC_OFF_CTRL, 32'h102);
        wr(`CFC_OFF_CMD, {28'h0, `CFC_CMD_CLRD});
        repeat (20) @(posedge clk);
        rc("held cmd", `CFC_OFF_CMD, 32'h1);
        cmp("busy out", 32'h1, {31'h0, ser_o.busy});
        osc_run = 1'b1;
        cmd(`CFC_CMD_CLRD);
        rc("low speed", `CFC_OFF_STATUS, 32'hE3);
        wr(`CFC_OFF_CTRL, 32'h0);
        repeat (8) @(posedge clk);
        cmp("txd", 32'h0, {31'h0, ser_o.txd});
        rc("pins", `CFC_OFF_PINS, 32'h0D);
        ser_i.sclk <= 1'b1;
        wr(`CFC_OFF_CTRL, 32'h10);
        repeat (8) @(posedge clk);
        rc("async pins", `CFC_OFF_PINS, 32'h07);
        ser_i <= '0;
        wr(`CFC_OFF_CTRL, 32'h100);
        $display("serial test done");
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_basic();
        t_arith();
        t_clk_ser();
        results();
    end

    initial begin
        #400000;
        err_total++;
        results();
    end
endmodule
